// file: logic/tmrcl_top.sv
// Interrupt clear, status, mask and timer A/B interval-load registers
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module tmrcl_top
   import tmrcl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic mode_32,
   input wire logic [10:0] irq_event,
   output logic [31:0] rdata,
   output logic [10:0] raw_status,
   output logic [10:0] masked_status,
   output logic irq,
   output logic [15:0] a_reload,
   output logic [15:0] b_reload,
   output logic a_load
);

   // Register state, its next value and the bus request
   tmrcl_state_t st;
   tmrcl_state_t next_st;
   tmrcl_bus_t bus;

   // Register map, byte offsets on the 8-bit address
   //   0x18  interrupt enable (mask), read/write, bits 10:8 and 3:0
   //   0x1c  raw status, read only, set by events
   //   0x20  masked status, read only, raw status gated by the enable
   //   0x24  write-one clear of both status registers, reads zero
   //   0x28  timer A reload, lower half A, upper half B alias in 32-bit mode
   //   0x2c  timer B reload, writes ignored in 32-bit mode
   // Every other address reads zero and ignores writes.

   // Bit layout shared by enable, raw, masked and clear registers
   //   10    timer B capture event
   //   9     timer B capture match
   //   8     timer B time-out
   //   7:4   reserved, always zero, writes ignored
   //   3     real-time-clock event
   //   2     timer A capture event
   //   1     timer A capture match
   //   0     timer A time-out
   //   31:11 reserved, always zero, writes ignored

   // Bus timing
   //   A strobe is taken at the rising edge with ce high.
   //   A write shows on the outputs one cycle later.
   //   The read word stands for one ce-high cycle after the read strobe
   //   and is zero after every other ce-high cycle, so no hold logic is needed.
   //   The bus never waits; back-to-back strobes are fine.

   // Clock enable
   //   With ce low every flop holds, including the read word and the
   //   timer A load strobe, so a strobe or event in that cycle is lost.
   //   The upstream logic keeps events and strobes for a ce-high cycle.

   // Width configuration
   //   mode_32 is a level from logic on this clock, read with no sync.
   //   B reload keeps its value when the configuration changes, so a
   //   return to 32-bit mode shows the last B value in the upper half.
   //   In 16-bit mode the upper half of the A word reads zero and its
   //   write data is dropped; B is then written through its own register.

   // Hazards
   //   An event and a clear of the same bit in one cycle leave it set,
   //   so software that clears and still finds the bit set knows that a
   //   fresh event arrived.
   //   An enable write and its masked copy move in the same cycle, so irq
   //   follows the new enable one cycle after the write.
   //   A status read returns the value before any event in that cycle.

   // Address decode, one line per register
   logic hit_mask;
   logic hit_raw;
   logic hit_msk_stat;
   logic hit_clear;
   logic hit_a_reload;
   logic hit_b_reload;

   // Accepted writes
   logic wr_mask;
   logic wr_clear;
   logic wr_a_reload;
   logic wr_b_reload;

   // Accepted reads
   logic rd_mask;
   logic rd_raw;
   logic rd_msk_stat;
   logic rd_a_reload;
   logic rd_b_reload;

   // Named clear fields of the clear register
   logic b_capture_event_clear;
   logic b_capture_match_clear;
   logic b_timeout_clear;
   logic rtc_event_clear;
   logic a_capture_event_clear;
   logic a_capture_match_clear;
   logic a_timeout_clear;
   logic [10:0] clear_bits;

   // Write side values
   logic [10:0] next_mask;
   logic [15:0] reload_lower_field;
   logic [15:0] reload_upper_field;
   logic upper_write_ok;
   logic b_write_ok;
   logic [15:0] next_a_reload;
   logic [15:0] next_b_reload;

   // Status values
   logic [10:0] event_bits;
   logic [10:0] next_raw;
   logic [10:0] next_masked;
   logic next_irq;

   // Read side values
   logic [15:0] rd_lower;
   logic [15:0] rd_upper;
   logic [31:0] rd_word_mask;
   logic [31:0] rd_word_raw;
   logic [31:0] rd_word_msk_stat;
   logic [31:0] rd_word_a_reload;
   logic [31:0] rd_word_b_reload;
   logic [31:0] next_rdata;

   // Gather the bus signals into one request
   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // Full 8-bit compare so no register shows up again in the holes
   assign hit_mask = (bus.addr == TMRCL_OFS_MASK);
   assign hit_raw = (bus.addr == TMRCL_OFS_RAW);
   assign hit_msk_stat = (bus.addr == TMRCL_OFS_MSK_STAT);
   assign hit_clear = (bus.addr == TMRCL_OFS_CLEAR);
   assign hit_a_reload = (bus.addr == TMRCL_OFS_A_RELOAD);
   assign hit_b_reload = (bus.addr == TMRCL_OFS_B_RELOAD);

   // Writes; the status registers have no write path
   assign wr_mask = bus.wr & hit_mask;
   assign wr_clear = bus.wr & hit_clear;
   assign wr_a_reload = bus.wr & hit_a_reload;
   assign wr_b_reload = bus.wr & hit_b_reload;

   // Reads; the clear register has no read path and returns zero
   assign rd_mask = bus.rd & hit_mask;
   assign rd_raw = bus.rd & hit_raw;
   assign rd_msk_stat = bus.rd & hit_msk_stat;
   assign rd_a_reload = bus.rd & hit_a_reload;
   assign rd_b_reload = bus.rd & hit_b_reload;

   // Each clear field acts only for a one written to it
   assign b_capture_event_clear = wr_clear & bus.wdata[TMRCL_BIT_B_CAP_EVENT];
   assign b_capture_match_clear = wr_clear & bus.wdata[TMRCL_BIT_B_CAP_MATCH];
   assign b_timeout_clear = wr_clear & bus.wdata[TMRCL_BIT_B_TIMEOUT];
   assign rtc_event_clear = wr_clear & bus.wdata[TMRCL_BIT_RTC_EVENT];
   assign a_capture_event_clear = wr_clear & bus.wdata[TMRCL_BIT_A_CAP_EVENT];
   assign a_capture_match_clear = wr_clear & bus.wdata[TMRCL_BIT_A_CAP_MATCH];
   assign a_timeout_clear = wr_clear & bus.wdata[TMRCL_BIT_A_TIMEOUT];

   // Clear vector in status layout; reserved positions never clear
   assign clear_bits = {b_capture_event_clear, b_capture_match_clear, b_timeout_clear,
      4'h0, rtc_event_clear, a_capture_event_clear,
      a_capture_match_clear, a_timeout_clear};

   // Enable register; reserved bits are dropped on the way in
   assign next_mask = wr_mask ? (bus.wdata[10:0] & TMRCL_IRQ_DEFINED) : st.mask;

   // Halves of a write to the timer A reload register
   assign reload_lower_field = bus.wdata[TMRCL_LOWER_LSB +: TMRCL_HALF_W];
   assign reload_upper_field = bus.wdata[TMRCL_UPPER_LSB +: TMRCL_HALF_W];

   // Upper half reaches B only in 32-bit mode, B's own register only in 16-bit mode
   assign upper_write_ok = wr_a_reload & mode_32;
   assign b_write_ok = wr_b_reload & ~mode_32;

   // Lower field always loads timer A
   assign next_a_reload = wr_a_reload ? reload_lower_field : st.a_reload;

   // Timer B reload from either path, otherwise held
   assign next_b_reload = upper_write_ok ? reload_upper_field :
      (b_write_ok ? reload_lower_field : st.b_reload);

   // Event pulses on reserved positions are ignored
   assign event_bits = irq_event & TMRCL_IRQ_DEFINED;

   // One status cell per interrupt bit
   for (genvar i = 0; i < TMRCL_NIRQ; i++) begin : g_status
      if (TMRCL_IRQ_DEFINED[i]) begin : g_used
         // Set wins over clear so an event is never lost
         assign next_raw[i] = event_bits[i] | (st.raw[i] & ~clear_bits[i]);
         // Masked copy follows the raw bit through the enable
         assign next_masked[i] = next_raw[i] & next_mask[i];
      end else begin : g_reserved
         // Reserved positions stay at zero
         assign next_raw[i] = 1'b0;
         assign next_masked[i] = 1'b0;
      end
   end

   // Level interrupt from any enabled pending bit
   assign next_irq = |next_masked;

   // Halves of the A reload word as read back
   assign rd_lower = st.a_reload;
   assign rd_upper = mode_32 ? st.b_reload : TMRCL_UPPER_16BIT;

   // Read words with reserved bits as zero
   assign rd_word_mask = {21'h0, st.mask};
   assign rd_word_raw = {21'h0, st.raw};
   assign rd_word_msk_stat = {21'h0, st.masked};
   assign rd_word_a_reload = {rd_upper, rd_lower};
   assign rd_word_b_reload = {16'h0, st.b_reload};

   // Next value of the whole state
   always_comb begin
      next_st = st;
      next_st.raw = next_raw;
      next_st.mask = next_mask;
      next_st.masked = next_masked;
      next_st.irq = next_irq;
      next_st.a_reload = next_a_reload;
      next_st.b_reload = next_b_reload;
      next_st.a_load = wr_a_reload;
      next_rdata = TMRCL_RDATA_RST;
      if (rd_mask) begin
         next_rdata = rd_word_mask;
      end else if (rd_raw) begin
         next_rdata = rd_word_raw;
      end else if (rd_msk_stat) begin
         next_rdata = rd_word_msk_stat;
      end else if (rd_a_reload) begin
         next_rdata = rd_word_a_reload;
      end else if (rd_b_reload) begin
         next_rdata = rd_word_b_reload;
      end
      next_st.rdata = next_rdata;
   end

   // State register with clock enable
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st.raw <= TMRCL_IRQ_RST;
         st.mask <= TMRCL_IRQ_RST;
         st.masked <= TMRCL_IRQ_RST;
         st.irq <= 1'b0;
         st.a_reload <= TMRCL_RELOAD_RST;
         st.b_reload <= TMRCL_RELOAD_RST;
         st.a_load <= 1'b0;
         st.rdata <= TMRCL_RDATA_RST;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops
   assign rdata = st.rdata;
   assign raw_status = st.raw;
   assign masked_status = st.masked;
   assign irq = st.irq;
   assign a_reload = st.a_reload;
   assign b_reload = st.b_reload;
   assign a_load = st.a_load;

endmodule
`default_nettype wire

// file: pkg/tmrcl_pkg.sv
// Constants and types for the timer interrupt clear and interval-load block
package tmrcl_pkg;
   // Register bus geometry
   localparam int TMRCL_AW = 8;
   localparam int TMRCL_DW = 32;
   localparam int TMRCL_NIRQ = 11;
   // Byte offsets of the registers
   localparam logic [7:0] TMRCL_OFS_MASK = 8'h18;
   localparam logic [7:0] TMRCL_OFS_RAW = 8'h1c;
   localparam logic [7:0] TMRCL_OFS_MSK_STAT = 8'h20;
   localparam logic [7:0] TMRCL_OFS_CLEAR = 8'h24;
   localparam logic [7:0] TMRCL_OFS_A_RELOAD = 8'h28;
   localparam logic [7:0] TMRCL_OFS_B_RELOAD = 8'h2c;
   // Interrupt bit positions
   localparam int TMRCL_BIT_B_CAP_EVENT = 10;
   localparam int TMRCL_BIT_B_CAP_MATCH = 9;
   localparam int TMRCL_BIT_B_TIMEOUT = 8;
   localparam int TMRCL_BIT_RTC_EVENT = 3;
   localparam int TMRCL_BIT_A_CAP_EVENT = 2;
   localparam int TMRCL_BIT_A_CAP_MATCH = 1;
   localparam int TMRCL_BIT_A_TIMEOUT = 0;
   // Defined interrupt bits; 7:4 are reserved
   localparam logic [10:0] TMRCL_IRQ_DEFINED = 11'h70f;
   // Load field positions and reset values
   localparam int TMRCL_LOWER_LSB = 0;
   localparam int TMRCL_UPPER_LSB = 16;
   localparam int TMRCL_HALF_W = 16;
   localparam logic [15:0] TMRCL_RELOAD_RST = 16'hffff;
   localparam logic [15:0] TMRCL_UPPER_16BIT = 16'h0000;
   localparam logic [10:0] TMRCL_IRQ_RST = 11'h000;
   localparam logic [31:0] TMRCL_RDATA_RST = 32'h0000_0000;

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } tmrcl_bus_t;

   // Whole block state
   typedef struct packed {
      logic [10:0] raw;
      logic [10:0] mask;
      logic [10:0] masked;
      logic irq;
      logic [15:0] a_reload;
      logic [15:0] b_reload;
      logic a_load;
      logic [31:0] rdata;
   } tmrcl_state_t;
endpackage

// file: dv/tmrcl_top_assertions.sv
// Checker of the timer interrupt clear and reload ports
`timescale 1ns/1ps
`default_nettype none
module tmrcl_chk (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic mode_32,
   input wire logic [10:0] irq_event,
   input wire logic [10:0] raw_status,
   input wire logic [10:0] masked_status,
   input wire logic irq,
   input wire logic [15:0] b_reload,
   input wire logic a_load
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Clear and timer A load writes
   wire logic clr = wr && ce && addr == 8'h24;
   wire logic ld = wr && ce && addr == 8'h28;
   AST_CLR: assert property (clr |=> !(raw_status & $past(wdata[10:0] & ~irq_event))) else $error("clear");
   AST_HOLD: assert property (clr |=> !($past(raw_status & ~wdata[10:0]) & ~raw_status)) else $error("hold");
   AST_SET: assert property (ce |=> !($past(irq_event) & 11'h70f & ~raw_status)) else $error("set");
   AST_MSK: assert property (!(masked_status & ~raw_status)) else $error("mask");
   AST_IRQ: assert property (irq == |masked_status) else $error("irq");
   AST_RSV: assert property (!raw_status[7:4] && !masked_status[7:4]) else $error("reserved");
   AST_LDA: assert property (ce |=> a_load == $past(ld)) else $error("load");
   AST_LDB: assert property (ld |=> b_reload == ($past(mode_32) ? $past(wdata[31:16]) : $past(b_reload)))
      else $error("upper");
   cover property (clr && |irq_event);
   cover property (ld && !mode_32);
   cover property (irq);
endmodule
bind tmrcl_top tmrcl_chk u_chk (.*);
`default_nettype wire

// file: dv/tmrcl_top_tb.sv
// Self-checking bench of the interrupt clear and reload block
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; $display("unexpected %s %h %h", n, e, s); end end
module tmrcl_top_tb;
   logic ref_clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, mode_32 = 1'b1, ce = 1'b1, irq, a_load, p;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [10:0] irq_event = 11'h0, raw_status, masked_status, ex;
   logic [15:0] a_reload, b_reload;
   int error_cnt = 0, samples_checked = 0;
   tmrcl_top u_dut (.*);
   // Bus cycle, a read when rn is set
   task automatic bus(input logic rn, input logic [7:0] a, input logic [31:0] v = 32'h0, input logic [10:0] e = 11'h0);
      {addr, wdata, wr, rd, irq_event} <= {a, v, !rn, rn, e};
      @(posedge ref_clk);
      {wr, rd, irq_event} <= 13'h0;
      #1 d = rdata;
      p = a_load;
      @(posedge ref_clk);
   endtask
   // Load register in both widths
   task automatic t_load();
      bus(1'b1, 8'h28);
      `CK("rst", 32'hffff_ffff, d)
      bus(1'b0, 8'h28, 32'h1234_5678);
      `CK("ld32", 1'b1, p)
      `CK("b32", 16'h1234, b_reload)
      bus(1'b1, 8'h28);
      `CK("rd32", 32'h1234_5678, d)
      `CK("ld0", 1'b0, p)
      bus(1'b0, 8'h2c, 32'h5555);
      bus(1'b1, 8'h2c);
      `CK("bro", 32'h1234, d)
      mode_32 <= 1'b0;
      bus(1'b0, 8'h28, 32'habcd_9876);
      `CK("a16", 16'h9876, a_reload)
      `CK("b16", 16'h1234, b_reload)
      bus(1'b1, 8'h28);
      `CK("rd16", 32'h0000_9876, d)
      bus(1'b0, 8'h2c, 32'h4321);
      mode_32 <= 1'b1;
      bus(1'b1, 8'h28);
      `CK("alias", 32'h4321_9876, d)
   endtask
   // Events, mask, per-bit clear
   task automatic t_irq();
      ex = 11'h70f;
      bus(1'b0, 8'hfc, 32'h0, 11'h7ff);
      `CK("raw", ex, raw_status)
      `CK("msk0", 11'h0, masked_status)
      bus(1'b0, 8'h18, 32'h100);
      `CK("irq1", 1'b1, irq)
      `CK("msk", 11'h100, masked_status)
      bus(1'b1, 8'h20);
      `CK("rdm", 32'h100, d)
      bus(1'b1, 8'h24);
      `CK("rdc", 32'h0, d)
      for (int i = 10; i >= 0; i--) begin
         bus(1'b0, 8'h24, 32'(ex) & (32'h1 << i));
         ex[i] = 1'b0;
         `CK("clr", ex, raw_status)
      end
      `CK("irq0", 1'b0, irq)
      bus(1'b0, 8'h24, 32'h1, 11'h1);
      `CK("race", 11'h1, raw_status)
      ce <= 1'b0;
      bus(1'b0, 8'h18, 32'h70f, 11'h100);
      ce <= 1'b1;
      `CK("ce", 11'h1, raw_status)
      bus(1'b1, 8'h18);
      `CK("cem", 32'h100, d)
   endtask
   // Counts and verdict
   task automatic end_of_test();
      $display("%0d of %0d checks bad", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Clock, reset, scenarios
   initial forever #5 ref_clk = ~ref_clk;
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_load();
      t_irq();
      end_of_test();
   end
endmodule
`default_nettype wire
